// ---- hdl/dummy_counter.sv ----
// Purpose: Counts dummy serial clock cycles of one read.
// Assumes: i_tick is a one-cycle enable per serial clock cycle.
// Notes:   o_done pulses for one cycle after the tick that ends the last dummy cycle.
`timescale 1ns/1ps
`default_nettype none
`include "wait_state_regs.svh"

module dummy_counter (
   input  wire logic              i_sys_clk,
   input  wire logic              i_reset_n,
   input  wire logic              i_load,
   input  wire logic [`CNT_W-1:0] i_count,
   input  wire logic              i_tick,
   output logic                   o_busy,
   output logic                   o_done
);

   logic [`CNT_W-1:0] remain_q;
   logic [`CNT_W-1:0] remain_d;
   logic              busy_d;
   logic              done_d;
   logic              last_tick;

   assign last_tick = o_busy & i_tick & (remain_q == 5'd1);
   assign remain_d  = i_load ? i_count :
                      (o_busy & i_tick) ? remain_q - 5'd1 : remain_q;
   assign busy_d    = i_load ? (i_count != 5'd0) :
                      (last_tick ? 1'b0 : o_busy);
   assign done_d    = last_tick & ~i_load;

   // ==================================================================
   // Counter registers
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         remain_q <= 5'd0;
         o_busy   <= 1'b0;
         o_done   <= 1'b0;
      end else begin
         remain_q <= remain_d;
         o_busy   <= busy_d;
         o_done   <= done_d;
      end
   end

endmodule

`default_nettype wire

// ---- hdl/latency_decode.sv ----
// Purpose: Maps a 4-bit wait-state code to its dummy-cycle count.
// Assumes: Purely combinational.
// Notes:   Unsupported codes give count zero and no support flag.
`timescale 1ns/1ps
`default_nettype none
`include "wait_state_regs.svh"

module latency_decode (
   input  wire logic [`WAIT_W-1:0] i_code_a,
   input  wire logic [`WAIT_W-1:0] i_code_b,
   output logic      [`CNT_W-1:0]  o_count_a,
   output logic                    o_ok_a,
   output logic      [`CNT_W-1:0]  o_count_b,
   output logic                    o_ok_b
);

   // ==================================================================
   // Code to count table
   function automatic logic [`CNT_W-1:0] dummy_count(
      input logic [`WAIT_W-1:0] code
   );
      logic [`CNT_W-1:0] n;
      n = `DUMMY_NONE;
      case (code)
         4'hF:    n = `DUMMY_CODE_F; // see [RL5]
         4'hD:    n = `DUMMY_CODE_D; // see [RL6]
         4'hB:    n = `DUMMY_CODE_B; // see [RL7]
         4'h9:    n = `DUMMY_CODE_9; // see [RL8]
         4'h8:    n = `DUMMY_CODE_8; // see [RL9]
         4'h7:    n = `DUMMY_CODE_7; // see [RL10]
         4'h6:    n = `DUMMY_CODE_6; // see [RL11]
         4'h5:    n = `DUMMY_CODE_5; // see [RL12]
         4'h4:    n = `DUMMY_CODE_4; // see [RL13]
         4'h3:    n = `DUMMY_CODE_3; // see [RL14]
         4'h2:    n = `DUMMY_CODE_2; // see [RL15]
         4'h1:    n = `DUMMY_CODE_1; // see [RL16]
         default: n = `DUMMY_NONE;   // see [RL17] [RL18] [RL19]
      endcase
      return n;
   endfunction

   assign o_count_a = dummy_count(i_code_a);
   assign o_ok_a    = (dummy_count(i_code_a) != `DUMMY_NONE);
   assign o_count_b = dummy_count(i_code_b);
   assign o_ok_b    = (dummy_count(i_code_b) != `DUMMY_NONE);

endmodule

`default_nettype wire

// ---- hdl/wait_state_config.sv ----
// Purpose: Read wait-state configuration register and dummy-cycle
//          sequencing of a serial NOR flash read.
// Assumes: A serial front end delivers decoded commands and a one-cycle
//          enable per serial clock; all inputs synchronous to i_sys_clk.
// Notes:   Writes with an unsupported latency code are refused.
//
// How it works
// [RL1] Wait-state field is 4 bits at bit 0 of register 03h.
// [RL2] Opcode 71h writes and 65h reads this register.
// [RL3] Register access only through commands carrying the register address.
// [RL4] Dummy cycle count comes from the wait-state field.
// [RL5] Code 01111b gives 28 dummy cycles.
// [RL6] Code 01101b gives 26 dummy cycles.
// [RL7] Code 01011b gives 24 dummy cycles.
// [RL8] Code 01001b gives 22 dummy cycles.
// [RL9] Code 01000b gives 20 dummy cycles.
// [RL10] Code 00111b gives 18 dummy cycles.
// [RL11] Code 00110b gives 16 dummy cycles.
// [RL12] Code 00101b gives 14 dummy cycles.
// [RL13] Code 00100b gives 12 dummy cycles.
// [RL14] Code 00011b gives 10 dummy cycles.
// [RL15] Code 00010b gives 8 dummy cycles.
// [RL16] Code 00001b gives 6 dummy cycles.
// [RL17] 30 dummy cycles are not supported.
// [RL18] 4 dummy cycles are not supported.
// [RL19] 2 dummy cycles are not supported.
// [RL20] New code applies to later reads between address and first data.
`timescale 1ns/1ps
`default_nettype none
`include "wait_state_regs.svh"

module wait_state_config
   import wait_state_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_cmd_valid,
   input  wire logic [7:0]  i_cmd_opcode,
   input  wire logic [23:0] i_cmd_addr,
   input  wire logic [7:0]  i_cmd_wdata,
   input  wire logic        i_sck_en,
   input  wire logic        i_read_start,
   input  wire logic        i_read_end,
   output logic      [7:0]  o_rd_data,
   output logic             o_rd_valid,
   output logic             o_wr_done,
   output logic             o_wr_refused,
   output logic             o_addr_miss,
   output logic             o_dummy_busy,
   output logic             o_data_start,
   output logic             o_data_phase,
   output logic      [3:0]  o_wait_code
);

   // ==================================================================
   // Declarations
   logic [7:0]         cfg_q;
   logic [7:0]         cfg_d;
   logic [7:0]         rd_data_d;
   logic               rd_valid_d;
   logic               wr_done_d;
   logic               wr_refused_d;
   logic               addr_miss_d;
   logic               data_phase_d;
   read_state_t        state_q;
   read_state_t        state_d;

   logic               is_write;
   logic               is_read;
   logic               addr_hit;
   logic               idle;
   logic               write_take;
   logic               read_take;
   logic [`WAIT_W-1:0] cur_code;
   logic [`WAIT_W-1:0] new_code;
   logic [`CNT_W-1:0]  cur_count;
   logic               cur_ok;
   logic [`CNT_W-1:0]  new_count;
   logic               new_ok;
   logic               load;
   logic               cnt_busy;
   logic               cnt_done;

   // ==================================================================
   // Command decode
   assign is_write   = i_cmd_valid & (i_cmd_opcode == `OP_WRITE_REG); // see [RL2]
   assign is_read    = i_cmd_valid & (i_cmd_opcode == `OP_READ_REG);  // see [RL2]
   assign addr_hit   = (i_cmd_addr == `CFG2_ADDR);                    // see [RL3]
   assign idle       = (state_q == ST_IDLE);
   assign write_take = is_write & addr_hit & idle;
   assign read_take  = is_read & addr_hit;

   // ==================================================================
   // Latency decode of stored and incoming codes
   assign cur_code = cfg_q[`WAIT_MSB:`WAIT_LSB];       // see [RL1]
   assign new_code = i_cmd_wdata[`WAIT_MSB:`WAIT_LSB];

   latency_decode u_decode (
      .i_code_a  (cur_code),
      .i_code_b  (new_code),
      .o_count_a (cur_count),
      .o_ok_a    (cur_ok),
      .o_count_b (new_count),
      .o_ok_b    (new_ok)
   );

   // ==================================================================
   // Register update and answers
   assign cfg_d = (write_take & new_ok) ? i_cmd_wdata : cfg_q; // see [RL1]

   // Unsupported codes never reach the register
   assign wr_refused_d = is_write & addr_hit & (~new_ok | ~idle); // see [RL17] [RL18] [RL19]
   assign wr_done_d    = write_take & new_ok;
   assign rd_valid_d   = read_take;                                // see [RL2]
   assign rd_data_d    = read_take ? cfg_q : o_rd_data;
   assign addr_miss_d  = (is_write | is_read) & ~addr_hit;        // see [RL3]

   // ==================================================================
   // Read sequencing
   // Count latched at read start from the current field
   assign load = idle & i_read_start & cur_ok;                     // see [RL4] [RL20]

   dummy_counter u_counter (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_load    (load),
      .i_count   (cur_count),
      .i_tick    (i_sck_en),
      .o_busy    (cnt_busy),
      .o_done    (cnt_done)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (load) begin
               state_d = ST_DUMMY;
            end
         end
         ST_DUMMY: begin
            if (i_read_end) begin
               state_d = ST_IDLE;
            end else if (cnt_done) begin
               state_d = ST_DATA;                               // see [RL20]
            end
         end
         ST_DATA: begin
            if (i_read_end) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   assign data_phase_d = (state_d == ST_DATA);

   // ==================================================================
   // Registers
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cfg_q        <= `CFG2_RESET;
         state_q      <= ST_IDLE;
         o_rd_data    <= 8'h00;
         o_rd_valid   <= 1'b0;
         o_wr_done    <= 1'b0;
         o_wr_refused <= 1'b0;
         o_addr_miss  <= 1'b0;
         o_data_phase <= 1'b0;
      end else begin
         cfg_q        <= cfg_d;
         state_q      <= state_d;
         o_rd_data    <= rd_data_d;
         o_rd_valid   <= rd_valid_d;
         o_wr_done    <= wr_done_d;
         o_wr_refused <= wr_refused_d;
         o_addr_miss  <= addr_miss_d;
         o_data_phase <= data_phase_d;
      end
   end

   // ==================================================================
   // Outputs straight from flops
   assign o_wait_code  = cfg_q[`WAIT_MSB:`WAIT_LSB];
   assign o_dummy_busy = cnt_busy;
   assign o_data_start = cnt_done;

endmodule

`default_nettype wire

// ---- hdl/wait_state_pkg.sv ----
// Purpose: Types shared by the wait-state configuration design.
// Assumes: Compiled before the modules.
// Notes:   Constants live in wait_state_regs.svh.
package wait_state_pkg;

   // ==================================================================
   // Read sequence states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DUMMY,
      ST_DATA
   } read_state_t;

endpackage

// ---- hdl/wait_state_regs.svh ----
// Purpose: Offsets, field positions, opcodes and reset values of the
//          read wait-state configuration register.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Definitions only.
`ifndef WAIT_STATE_REGS_SVH
`define WAIT_STATE_REGS_SVH

// =====================================================================
// Register location and field
`define CFG2_ADDR      24'h000003
`define WAIT_LSB       0
`define WAIT_MSB       3
`define WAIT_W         4

// =====================================================================
// Register access opcodes
`define OP_WRITE_REG   8'h71
`define OP_READ_REG    8'h65

// =====================================================================
// Reset value of the configuration byte, code 8h gives 20 cycles
`define CFG2_RESET     8'h08

// =====================================================================
// Dummy cycles selected by each supported wait-state code
`define DUMMY_CODE_F   5'h1C
`define DUMMY_CODE_D   5'h1A
`define DUMMY_CODE_B   5'h18
`define DUMMY_CODE_9   5'h16
`define DUMMY_CODE_8   5'h14
`define DUMMY_CODE_7   5'h12
`define DUMMY_CODE_6   5'h10
`define DUMMY_CODE_5   5'h0E
`define DUMMY_CODE_4   5'h0C
`define DUMMY_CODE_3   5'h0A
`define DUMMY_CODE_2   5'h08
`define DUMMY_CODE_1   5'h06
`define DUMMY_NONE     5'h00

// =====================================================================
// Dummy count width
`define CNT_W          5

`endif

// ---- tb/host_model.sv ----
// Purpose: Host side of the read: serial clock enables and a tick count.
// Assumes: i_go pulses while the read sequence is idle.
// Notes:   Serial clock stands still outside frames.
`timescale 1ns/1ps
`default_nettype none

module host_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_reset_n,
   input  wire logic       i_go,
   input  wire logic       i_slow,
   input  wire logic       i_data_start,
   output logic            o_sck_en,
   output logic      [5:0] o_ticks
);
   logic       run_q;
   logic [5:0] cnt_q;
   logic [1:0] div_q;

   // =================================================================
   // Tick source and dummy count
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         run_q <= 1'b0;
         cnt_q <= 6'h00;
         div_q <= 2'h0;
         o_sck_en <= 1'b0;
         o_ticks <= 6'h00;
      end else if (i_go) begin
         run_q <= 1'b1;
         cnt_q <= 6'h00;
         div_q <= 2'h0;
         o_sck_en <= 1'b0;
      end else if (i_data_start || !run_q) begin
         run_q <= 1'b0;
         o_sck_en <= 1'b0;
         if (run_q)
            o_ticks <= cnt_q;
      end else begin
         div_q <= div_q + 2'h1;
         o_sck_en <= !i_slow || div_q == 2'h3;
         if (o_sck_en)
            cnt_q <= cnt_q + 6'h01;
      end
   end
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench of the wait-state configuration block.
// Assumes: host_model supplies the serial clock enables.
// Notes:   Every code is written and read back; each supported code is used for one read.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic        i_sys_clk, i_reset_n, i_cmd_valid, i_sck_en;
   logic        i_read_start, i_read_end, go, slow;
   logic [7:0]  i_cmd_opcode, i_cmd_wdata, o_rd_data;
   logic [23:0] i_cmd_addr;
   logic        o_rd_valid, o_wr_done, o_wr_refused, o_addr_miss;
   logic        o_dummy_busy, o_data_start, o_data_phase;
   logic [3:0]  o_wait_code;
   logic [5:0]  ticks;
   int          n_fail, checks_done;

   wait_state_config wait_state_config_inst (.i_sys_clk, .i_reset_n,
      .i_cmd_valid, .i_cmd_opcode, .i_cmd_addr, .i_cmd_wdata, .i_sck_en,
      .i_read_start, .i_read_end, .o_rd_data, .o_rd_valid, .o_wr_done,
      .o_wr_refused, .o_addr_miss, .o_dummy_busy, .o_data_start,
      .o_data_phase, .o_wait_code);
   host_model host_model_inst (.i_sys_clk, .i_reset_n, .i_go(go),
      .i_slow(slow), .i_data_start(o_data_start), .o_sck_en(i_sck_en),
      .o_ticks(ticks));

   // =================================================================
   // Helpers
   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   function automatic logic [5:0] exp_cnt(logic [3:0] c);
      if (c == 4'h0 || (c > 4'h9 && !c[0]))
         return 6'h00;
      if (c < 4'h9)
         return 6'h04 + {1'b0, c, 1'b0};
      return 6'h0D + {2'h0, c};
   endfunction

   task automatic cmd(logic [7:0] op, logic [23:0] ad, logic [7:0] wd);
      @(posedge i_sys_clk) #1;
      i_cmd_valid = 1'b1;
      i_cmd_opcode = op;
      i_cmd_addr = ad;
      i_cmd_wdata = wd;
      @(posedge i_sys_clk) #1;
      i_cmd_valid = 1'b0;
   endtask

   // =================================================================
   // Scenarios
   task automatic rd_seq(logic [5:0] n, logic sl, logic [3:0] code);
      int k;
      @(posedge i_sys_clk) #1;
      i_read_start = 1'b1;
      go = 1'b1;
      slow = sl;
      @(posedge i_sys_clk) #1;
      i_read_start = 1'b0;
      go = 1'b0;
      check("busy", o_dummy_busy, 1'b1);
      for (k = 0; k < 200 && o_data_start !== 1'b1; k++)
         @(posedge i_sys_clk) #1;
      check("start", o_data_start, 1'b1);
      check("busy end", o_dummy_busy, 1'b0);
      check("phase early", o_data_phase, 1'b0);
      @(posedge i_sys_clk) #1;
      check("start pulse", o_data_start, 1'b0);
      check("phase", o_data_phase, 1'b1);
      check("dummy count", ticks, n);
      cmd(8'h71, 24'h000003, 8'h01);
      check("busy refuse", o_wr_refused, 1'b1);
      check("code kept", o_wait_code, code);
      i_read_end = 1'b1;
      @(posedge i_sys_clk) #1;
      i_read_end = 1'b0;
      check("phase end", o_data_phase, 1'b0);
   endtask

   task automatic t_abort;
      int k;
      @(posedge i_sys_clk) #1;
      i_read_start = 1'b1;
      go = 1'b1;
      slow = 1'b0;
      @(posedge i_sys_clk) #1;
      i_read_start = 1'b0;
      go = 1'b0;
      i_read_end = 1'b1;
      @(posedge i_sys_clk) #1;
      i_read_end = 1'b0;
      check("abort phase", o_data_phase, 1'b0);
      for (k = 0; k < 200 && o_dummy_busy !== 1'b0; k++)
         @(posedge i_sys_clk) #1;
      @(posedge i_sys_clk) #1;
      check("abort no data", o_data_phase, 1'b0);
      check("abort count", ticks, 6'h1C);
   endtask

   task automatic t_codes;
      logic [7:0] cur;
      logic [5:0] n;
      cur = 8'h08;
      check("reset code", o_wait_code, 4'h8);
      for (int i = 0; i < 16; i++) begin
         n = exp_cnt(4'(i));
         cmd(8'h71, 24'h000003, {~4'(i), 4'(i)});
         check("done", o_wr_done, n != 6'h00);
         check("refuse", o_wr_refused, n == 6'h00);
         if (n != 6'h00) cur = {~4'(i), 4'(i)};
         check("code", o_wait_code, cur[3:0]);
         cmd(8'h65, 24'h000003, 8'h00);
         check("read valid", o_rd_valid, 1'b1);
         check("read byte", o_rd_data, cur);
         if (n != 6'h00) rd_seq(n, i[1], cur[3:0]);
      end
   endtask

   task automatic t_miss;
      cmd(8'h71, 24'h000004, 8'h01);
      check("miss wr", o_addr_miss, 1'b1);
      check("miss wr done", o_wr_done, 1'b0);
      cmd(8'h65, 24'h800003, 8'h00);
      check("miss rd", o_addr_miss, 1'b1);
      check("miss rd valid", o_rd_valid, 1'b0);
      cmd(8'h72, 24'h000003, 8'h01);
      check("other op", o_wr_done, 1'b0);
      check("other code", o_wait_code, 4'hF);
   endtask

   // =================================================================
   // Clock, reset, sequence and watchdog
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   initial begin
      {i_reset_n, i_cmd_valid, i_read_start, i_read_end, go, slow} = '0;
      {i_cmd_opcode, i_cmd_wdata, i_cmd_addr} = '0;
      repeat (8) @(posedge i_sys_clk);
      #1 i_reset_n = 1'b1;
      check("reset byte", o_rd_data, 8'h00);
      t_codes;
      t_abort;
      t_miss;
      end_sim;
   end

   initial begin
      #500000;
      n_fail++;
      end_sim;
   end
endmodule

`default_nettype wire

// ---- tb/wait_state_config_assertions.sv ----
// Purpose: Port checks of the wait-state configuration block.
// Assumes: One clock domain.
// Notes:   Bound to every instance.
`timescale 1ns/1ps
`default_nettype none
`include "wait_state_regs.svh"

module wait_state_config_chk (
   input wire logic        i_sys_clk,
   input wire logic        i_reset_n,
   input wire logic        i_cmd_valid,
   input wire logic [7:0]  i_cmd_opcode,
   input wire logic [23:0] i_cmd_addr,
   input wire logic [7:0]  i_cmd_wdata,
   input wire logic        i_read_start,
   input wire logic        i_read_end,
   input wire logic [7:0]  o_rd_data,
   input wire logic        o_rd_valid,
   input wire logic        o_wr_done,
   input wire logic        o_wr_refused,
   input wire logic        o_addr_miss,
   input wire logic        o_dummy_busy,
   input wire logic        o_data_start,
   input wire logic        o_data_phase,
   input wire logic [3:0]  o_wait_code
);
   // =================================================================
   // Decoded requests
   wire logic       hit  = i_cmd_valid && i_cmd_addr == `CFG2_ADDR;
   wire logic       wr   = hit && i_cmd_opcode == `OP_WRITE_REG;
   wire logic       rd   = hit && i_cmd_opcode == `OP_READ_REG;
   wire logic       seq  = o_dummy_busy || o_data_phase || o_data_start;
   wire logic [3:0] c    = i_cmd_wdata[3:0];
   wire logic       bad  = c == 4'h0 || (c > 4'h9 && !c[0]);
   wire logic       cmd  = i_cmd_opcode == `OP_WRITE_REG ||
                           i_cmd_opcode == `OP_READ_REG;

   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   // =================================================================
   // Checks
   chk_write_store: assert property (
      wr && !seq && !i_read_start && !bad
      |=> o_wr_done && o_wait_code == $past(c))
      else $error("write not stored");
   chk_write_bad: assert property (
      wr && bad |=> o_wr_refused && !o_wr_done && $stable(o_wait_code))
      else $error("bad code accepted");
   chk_write_busy: assert property (
      wr && seq |=> o_wr_refused && $stable(o_wait_code))
      else $error("write during read accepted");
   chk_read_back: assert property (
      rd |=> o_rd_valid && o_rd_data[3:0] == $past(o_wait_code))
      else $error("read answer wrong");
   chk_addr_miss: assert property (
      i_cmd_valid && cmd && !hit
      |=> o_addr_miss && !o_rd_valid && $stable(o_wait_code))
      else $error("wrong address not flagged");
   chk_code_hold: assert property (
      !wr |=> $stable(o_wait_code))
      else $error("code changed without write");
   chk_dummy_begin: assert property (
      i_read_start && !seq |=> o_dummy_busy)
      else $error("dummy phase not entered");
   chk_start_phase: assert property (
      o_data_start |-> !o_data_phase && !o_dummy_busy && $past(o_dummy_busy))
      else $error("data start without dummy end");
   chk_phase_end: assert property (
      o_data_phase && i_read_end |=> !o_data_phase)
      else $error("data phase not ended");

   cover property (o_wr_refused);
   cover property (o_data_start);
   cover property (o_addr_miss);
endmodule

bind wait_state_config wait_state_config_chk wait_state_config_chk_inst (
   .i_sys_clk, .i_reset_n, .i_cmd_valid, .i_cmd_opcode, .i_cmd_addr,
   .i_cmd_wdata, .i_read_start, .i_read_end, .o_rd_data, .o_rd_valid,
   .o_wr_done, .o_wr_refused, .o_addr_miss, .o_dummy_busy, .o_data_start,
   .o_data_phase, .o_wait_code
);

`default_nettype wire
